// ### rtl/ebx_top.sv
// External address/data pins, bus holders and interrupt pin handling
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Low sixteen address lines carry every external access address.
// - Upper seven address lines driven only for program space accesses.
// - Address outputs float during hold and while float control is low.
// - Host wide select high turns low address lines into host inputs.
// - One shared 16-bit data bus serves all external spaces.
// - Data bus floats unless writing, and during reset or hold.
// - Data bus floats whenever float control is low.
// - Bus holders keep each undriven data line at its last level.
// - Acknowledge asserted while fetching the accepted interrupt vector.
// - Acknowledge output floats whenever float control is low.
// - Four interrupt lines prioritised, maskable, flags visible for polling.
// - Non-maskable interrupt ignores global mask and mask register.
// - Non-maskable request fetches from its own vector location.
// - Hold request granted with acknowledge; lines then float.
// - After reset release, execution starts at program address 0ff80.
module ebx_top #(
    parameter int ACC_CYC = ebx_pkg::ACC_CYC_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [ebx_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ebx_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ebx_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    input wire logic core_req,
    input wire ebx_pkg::ebx_space_t core_space,
    input wire logic core_wr,
    input wire logic [ebx_pkg::ADDR_W-1:0] core_addr,
    input wire logic [ebx_pkg::DATA_W-1:0] core_wdata,
    output logic core_busy,
    output logic core_done,
    output logic [ebx_pkg::DATA_W-1:0] core_rdata,
    output logic vec_done,
    output logic [ebx_pkg::LO_W-1:0] vec_addr,
    output logic [ebx_pkg::ADDR_W-1:0] ext_addr_o,
    output logic ext_addr_lo_oe,
    output logic ext_addr_hi_oe,
    input wire logic [ebx_pkg::LO_W-1:0] ext_addr_i,
    output logic [ebx_pkg::DATA_W-1:0] ext_data_o,
    output logic ext_data_oe,
    input wire logic [ebx_pkg::DATA_W-1:0] ext_data_i,
    output logic [ebx_pkg::DATA_W-1:0] ext_data_keep_o,
    output logic ext_data_keep_oe,
    input wire logic float_n,
    input wire logic hold_req_n,
    output logic hold_ack_n,
    input wire logic host_port_wide_select,
    output logic [ebx_pkg::LO_W-1:0] host_port_addr,
    input wire logic [ebx_pkg::NUM_INT-1:0] external_interrupt_line_n,
    input wire logic nmi_n,
    output logic interrupt_acknowledge_out_n,
    output logic interrupt_acknowledge_oe
);
    localparam int CNT_W = 8;

    generate
        if (ACC_CYC < 1 || ACC_CYC >= (1 << CNT_W)) begin : g_bad_acc
            $error("ACC_CYC must lie between 1 and 255");
        end
    endgenerate

    localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACC_CYC - 1);

    typedef struct packed {
        ebx_pkg::ebx_state_t st;
        logic [CNT_W-1:0] cnt;
        ebx_pkg::ebx_space_t space;
        logic wr;
        logic boot;
        logic [ebx_pkg::ADDR_W-1:0] addr;
        logic [ebx_pkg::DATA_W-1:0] wdata;
        logic addr_oe;
        logic data_oe;
        logic ack_n;
        logic hold_ack_n;
        logic [ebx_pkg::DATA_W-1:0] keep;
        logic [ebx_pkg::DATA_W-1:0] rdata;
        logic core_done;
        logic vec_done;
        logic [ebx_pkg::LO_W-1:0] vec_addr;
        logic [ebx_pkg::NUM_INT-1:0] int_mask;
        logic holder_en;
        logic glob_mask;
        logic [ebx_pkg::DATA_W-1:0] reg_rdata;
        logic [ebx_pkg::LO_W-1:0] host_addr;
    } ebx_st_t;

    localparam ebx_st_t ST_RST = '{
        st: ebx_pkg::ST_BOOT, cnt: '0, space: ebx_pkg::SP_PROG,
        wr: 1'b0, boot: 1'b0, addr: '0, wdata: '0, addr_oe: 1'b0,
        data_oe: 1'b0, ack_n: 1'b1, hold_ack_n: 1'b1, keep: '0,
        rdata: '0, core_done: 1'b0, vec_done: 1'b0, vec_addr: '0,
        int_mask: ebx_pkg::INT_MASK_RST, holder_en: ebx_pkg::HOLDER_RST,
        glob_mask: ebx_pkg::GMASK_RST, reg_rdata: '0, host_addr: '0
    };

    ebx_st_t cur_r;
    ebx_st_t cur_nxt;

    ebx_irq_if irq_bus ();

    ebx_irq u_irq (
        .mclk(mclk),
        .reset_n(reset_n),
        .bus(irq_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [ebx_pkg::LO_W-1:0] slot_addr(
        input logic [3:0] slot
    );
        slot_addr = ebx_pkg::RESET_VEC +
            (ebx_pkg::LO_W'(slot) << ebx_pkg::SLOT_SHIFT);
    endfunction

    function automatic logic [3:0] id_slot(input logic [2:0] id);
        if (id == ebx_pkg::ID_NMI) begin
            id_slot = ebx_pkg::SLOT_NMI;
        end else begin
            id_slot = ebx_pkg::SLOT_EXTERNAL_INTERRUPT_LINE + {1'b0, id};
        end
    endfunction

    function automatic logic reg_hit(
        input logic [ebx_pkg::REG_AW-1:0] a,
        input logic [ebx_pkg::REG_AW-1:0] which
    );
        reg_hit = (a == which);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Interrupt unit hookup

    assign irq_bus.ext_int_n = external_interrupt_line_n;
    assign irq_bus.nmi_n = nmi_n;
    assign irq_bus.int_mask = cur_r.int_mask;
    assign irq_bus.glob_mask = cur_r.glob_mask;
    assign irq_bus.ready = !core_busy && !core_req;
    assign irq_bus.clr_mask = (reg_wr &&
        reg_hit(reg_addr, ebx_pkg::REG_INT_FLAG)) ?
        reg_wdata[ebx_pkg::FLAG_W-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.core_done = 1'b0;
        cur_nxt.vec_done = 1'b0;

        // Holder follows what we drive, else whatever is on the wire
        cur_nxt.keep = ext_data_oe ? cur_r.wdata : ext_data_i;

        if (host_port_wide_select) begin
            cur_nxt.host_addr = ext_addr_i;
        end

        case (cur_r.st)
            ebx_pkg::ST_BOOT: begin
                // First fetch after reset release
                cur_nxt.st = ebx_pkg::ST_VEC;
                cur_nxt.boot = 1'b1;
                cur_nxt.space = ebx_pkg::SP_PROG;
                cur_nxt.wr = 1'b0;
                cur_nxt.addr = {{ebx_pkg::HI_W{1'b0}},
                    slot_addr(ebx_pkg::SLOT_RESET)};
                cur_nxt.addr_oe = 1'b1;
                cur_nxt.cnt = ACC_LAST;
            end
            ebx_pkg::ST_IDLE: begin
                if (irq_bus.take) begin
                    // Vector fetch with acknowledge low
                    cur_nxt.st = ebx_pkg::ST_VEC;
                    cur_nxt.boot = 1'b0;
                    cur_nxt.space = ebx_pkg::SP_PROG;
                    cur_nxt.wr = 1'b0;
                    cur_nxt.addr = {{ebx_pkg::HI_W{1'b0}},
                        slot_addr(id_slot(irq_bus.take_id))};
                    cur_nxt.addr_oe = 1'b1;
                    cur_nxt.ack_n = 1'b0;
                    cur_nxt.cnt = ACC_LAST;
                end else if (!hold_req_n) begin
                    // Grant only between accesses; lines float
                    cur_nxt.st = ebx_pkg::ST_HOLD;
                    cur_nxt.hold_ack_n = 1'b0;
                    cur_nxt.addr_oe = 1'b0;
                    cur_nxt.data_oe = 1'b0;
                end else if (core_req) begin
                    cur_nxt.st = ebx_pkg::ST_XFER;
                    cur_nxt.space = core_space;
                    cur_nxt.wr = core_wr;
                    cur_nxt.addr = core_addr;
                    cur_nxt.wdata = core_wdata;
                    cur_nxt.addr_oe = 1'b1;
                    cur_nxt.data_oe = core_wr;
                    cur_nxt.cnt = ACC_LAST;
                end
            end
            ebx_pkg::ST_XFER, ebx_pkg::ST_VEC: begin
                if (cur_r.cnt == '0) begin
                    if (!cur_r.wr) begin
                        cur_nxt.rdata = ext_data_i;
                    end
                    cur_nxt.core_done = (cur_r.st == ebx_pkg::ST_XFER);
                    cur_nxt.vec_done = (cur_r.st == ebx_pkg::ST_VEC);
                    if (cur_r.st == ebx_pkg::ST_VEC) begin
                        cur_nxt.vec_addr = cur_r.addr[ebx_pkg::LO_W-1:0];
                    end
                    cur_nxt.st = ebx_pkg::ST_IDLE;
                    cur_nxt.addr_oe = 1'b0;
                    cur_nxt.data_oe = 1'b0;
                    cur_nxt.ack_n = 1'b1;
                end else begin
                    cur_nxt.cnt = cur_r.cnt - 1'b1;
                end
            end
            ebx_pkg::ST_HOLD: begin
                if (hold_req_n) begin
                    cur_nxt.st = ebx_pkg::ST_IDLE;
                    cur_nxt.hold_ack_n = 1'b1;
                end
            end
            default: begin
                cur_nxt.st = ebx_pkg::ST_IDLE;
            end
        endcase

        // Taking a maskable interrupt sets the global mask; this beats a
        // software write in the same cycle
        if (reg_wr && reg_hit(reg_addr, ebx_pkg::REG_CORE_CTL)) begin
            cur_nxt.glob_mask = reg_wdata[ebx_pkg::CORE_GMASK_BIT];
        end
        if (irq_bus.take && cur_r.st == ebx_pkg::ST_IDLE &&
            irq_bus.take_id != ebx_pkg::ID_NMI) begin
            cur_nxt.glob_mask = 1'b1;
        end
        if (reg_wr && reg_hit(reg_addr, ebx_pkg::REG_INT_MASK)) begin
            cur_nxt.int_mask = reg_wdata[ebx_pkg::NUM_INT-1:0];
        end
        if (reg_wr && reg_hit(reg_addr, ebx_pkg::REG_BANK_CTL)) begin
            cur_nxt.holder_en = reg_wdata[ebx_pkg::BANK_HOLDER_BIT];
        end

        // Register read data stands only in the cycle after the strobe
        cur_nxt.reg_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ebx_pkg::REG_INT_MASK: begin
                    cur_nxt.reg_rdata[ebx_pkg::NUM_INT-1:0] = cur_r.int_mask;
                end
                ebx_pkg::REG_INT_FLAG: begin
                    cur_nxt.reg_rdata[ebx_pkg::FLAG_W-1:0] =
                        irq_bus.int_flag;
                end
                ebx_pkg::REG_BANK_CTL: begin
                    cur_nxt.reg_rdata[ebx_pkg::BANK_HOLDER_BIT] =
                        cur_r.holder_en;
                end
                ebx_pkg::REG_CORE_CTL: begin
                    cur_nxt.reg_rdata[ebx_pkg::CORE_GMASK_BIT] =
                        cur_r.glob_mask;
                end
                ebx_pkg::REG_STATUS: begin
                    cur_nxt.reg_rdata[2:0] = cur_r.st;
                    cur_nxt.reg_rdata[3] = ~cur_r.hold_ack_n;
                    cur_nxt.reg_rdata[4] = ~cur_r.ack_n;
                    cur_nxt.reg_rdata[5] = cur_r.boot;
                end
                default: begin
                    cur_nxt.reg_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur_r <= ST_RST;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins; float control acts at once, without waiting for a clock edge

    assign ext_addr_o = cur_r.addr;
    // Wide host mode hands the low lines to the outside host
    assign ext_addr_lo_oe = cur_r.addr_oe & float_n &
        ~host_port_wide_select;
    assign ext_addr_hi_oe = cur_r.addr_oe & float_n &
        (cur_r.space == ebx_pkg::SP_PROG);
    assign ext_data_o = cur_r.wdata;
    assign ext_data_oe = cur_r.data_oe & float_n;
    // Holder stays on under float too, so lines never drift
    assign ext_data_keep_o = cur_r.keep;
    assign ext_data_keep_oe = cur_r.holder_en & ~ext_data_oe;
    assign interrupt_acknowledge_out_n = cur_r.ack_n;
    assign interrupt_acknowledge_oe = float_n;
    assign hold_ack_n = cur_r.hold_ack_n;
    assign host_port_addr = cur_r.host_addr;

    assign core_busy = (cur_r.st != ebx_pkg::ST_IDLE) || !hold_req_n ||
        irq_bus.take;
    assign core_done = cur_r.core_done;
    assign core_rdata = cur_r.rdata;
    assign vec_done = cur_r.vec_done;
    assign vec_addr = cur_r.vec_addr;
    assign reg_rdata = cur_r.reg_rdata;
    // NMI flag is not gated by the mask register
    assign irq = |(irq_bus.int_flag[ebx_pkg::NUM_INT-1:0] & cur_r.int_mask)
        | irq_bus.int_flag[ebx_pkg::NMI_BIT];
endmodule

// ### rtl/ebx_pkg.sv
// Shared constants and types for the external bus and interrupt pin block
package ebx_pkg;
    localparam int ADDR_W = 23;
    localparam int LO_W = 16;
    localparam int HI_W = ADDR_W - LO_W;
    localparam int DATA_W = 16;
    localparam int NUM_INT = 4;
    localparam int FLAG_W = NUM_INT + 1;
    localparam int NMI_BIT = NUM_INT;
    localparam int ACC_CYC_DEF = 2;

    // Register indices on the plain register port
    localparam int REG_AW = 3;
    localparam logic [REG_AW-1:0] REG_INT_MASK = 3'h0;
    localparam logic [REG_AW-1:0] REG_INT_FLAG = 3'h1;
    localparam logic [REG_AW-1:0] REG_BANK_CTL = 3'h2;
    localparam logic [REG_AW-1:0] REG_CORE_CTL = 3'h3;
    localparam logic [REG_AW-1:0] REG_STATUS = 3'h4;

    localparam int BANK_HOLDER_BIT = 0;
    localparam int CORE_GMASK_BIT = 0;
    localparam logic [NUM_INT-1:0] INT_MASK_RST = 4'h0;
    localparam logic [FLAG_W-1:0] INT_FLAG_RST = 5'h00;
    localparam logic HOLDER_RST = 1'b1;
    localparam logic GMASK_RST = 1'b1;

    // Vector table: reset slot at the base, one slot per four words
    localparam logic [LO_W-1:0] RESET_VEC = 16'hff80;
    localparam logic [3:0] SLOT_RESET = 4'h0;
    localparam logic [3:0] SLOT_NMI = 4'h1;
    localparam logic [3:0] SLOT_EXTERNAL_INTERRUPT_LINE = 4'h4;
    localparam int SLOT_SHIFT = 2;
    localparam logic [2:0] ID_NMI = 3'h4;

    typedef enum logic [1:0] {
        SP_PROG = 2'b00,
        SP_DATA = 2'b01,
        SP_IO = 2'b10
    } ebx_space_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_VEC = 3'b011,
        ST_HOLD = 3'b100
    } ebx_state_t;
endpackage

// ### rtl/ebx_irq_if.sv
// Interface between the pin controller and its interrupt flag unit
`timescale 1ns/10ps
interface ebx_irq_if;
    logic [ebx_pkg::NUM_INT-1:0] ext_int_n;
    logic nmi_n;
    logic [ebx_pkg::NUM_INT-1:0] int_mask;
    logic glob_mask;
    logic [ebx_pkg::FLAG_W-1:0] clr_mask;
    logic ready;
    logic [ebx_pkg::FLAG_W-1:0] int_flag;
    logic take;
    logic [2:0] take_id;
    modport ctl (
        output ext_int_n, nmi_n, int_mask, glob_mask, clr_mask, ready,
        input int_flag, take, take_id
    );
    modport irq (
        input ext_int_n, nmi_n, int_mask, glob_mask, clr_mask, ready,
        output int_flag, take, take_id
    );
endinterface

// ### rtl/ebx_irq.sv
// Interrupt flag capture and fixed-priority acceptance
`timescale 1ns/10ps
module ebx_irq (
    input wire logic mclk,
    input wire logic reset_n,
    ebx_irq_if.irq bus
);
    typedef struct packed {
        logic [ebx_pkg::FLAG_W-1:0] flag;
        logic [ebx_pkg::NUM_INT-1:0] int_q;
        logic nmi_q;
        logic take;
        logic [2:0] id;
    } ebx_irq_st_t;

    ebx_irq_st_t cur_r;
    ebx_irq_st_t cur_nxt;
    logic [ebx_pkg::FLAG_W-1:0] set_v;

    // Falling edge on an active-low line marks a new request
    genvar g;
    generate
        for (g = 0; g < ebx_pkg::NUM_INT; g++) begin : g_edge
            assign set_v[g] = cur_r.int_q[g] & ~bus.ext_int_n[g];
        end
    endgenerate
    assign set_v[ebx_pkg::NMI_BIT] = cur_r.nmi_q & ~bus.nmi_n;

    always_comb begin
        logic [ebx_pkg::FLAG_W-1:0] taken;
        logic found;
        taken = '0;
        found = 1'b0;
        cur_nxt = cur_r;
        cur_nxt.int_q = bus.ext_int_n;
        cur_nxt.nmi_q = bus.nmi_n;
        cur_nxt.take = 1'b0;
        if (bus.ready && !cur_r.take) begin
            // Non-maskable first, ignoring both masks
            if (cur_r.flag[ebx_pkg::NMI_BIT]) begin
                found = 1'b1;
                cur_nxt.id = ebx_pkg::ID_NMI;
                taken[ebx_pkg::NMI_BIT] = 1'b1;
            end else if (!bus.glob_mask) begin
                // Line 0 has highest priority
                for (int i = ebx_pkg::NUM_INT - 1; i >= 0; i--) begin
                    if (cur_r.flag[i] && bus.int_mask[i]) begin
                        found = 1'b1;
                        cur_nxt.id = 3'(i);
                        taken = '0;
                        taken[i] = 1'b1;
                    end
                end
            end
        end
        cur_nxt.take = found;
        // A new edge wins over any clear in the same cycle
        cur_nxt.flag = (cur_r.flag & ~bus.clr_mask & ~taken) | set_v;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur_r <= '{flag: ebx_pkg::INT_FLAG_RST, int_q: '1, nmi_q: 1'b1,
                       take: 1'b0, id: 3'h0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign bus.int_flag = cur_r.flag;
    assign bus.take = cur_r.take;
    assign bus.take_id = cur_r.id;
endmodule

// ### dv/ebx_top_monitor.sv
// Concurrent checks on the pin block's bus and interrupt ports
`timescale 1ns/10ps
module ebx_top_monitor #(
    parameter int ACC_CYC = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic core_req,
    input wire logic core_busy,
    input wire ebx_pkg::ebx_space_t core_space,
    input wire logic core_wr,
    input wire logic [ebx_pkg::ADDR_W-1:0] core_addr,
    input wire logic [ebx_pkg::DATA_W-1:0] core_wdata,
    input wire logic [ebx_pkg::ADDR_W-1:0] ext_addr_o,
    input wire logic ext_addr_lo_oe,
    input wire logic ext_addr_hi_oe,
    input wire logic [ebx_pkg::DATA_W-1:0] ext_data_o,
    input wire logic ext_data_oe,
    input wire logic [ebx_pkg::DATA_W-1:0] ext_data_keep_o,
    input wire logic float_n,
    input wire logic hold_req_n,
    input wire logic hold_ack_n,
    input wire logic host_port_wide_select,
    input wire logic nmi_n,
    input wire logic interrupt_acknowledge_out_n,
    input wire logic interrupt_acknowledge_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_take;
        core_req && !core_busy;
    endsequence
    sequence s_take_wr;
        s_take ##0 core_wr;
    endsequence

    a_addr_float: assert property (
        !float_n || !hold_ack_n |-> !ext_addr_lo_oe && !ext_addr_hi_oe)
        else $error("address driven while floated");
    a_hi_prog: assert property (
        s_take ##0 core_space != ebx_pkg::SP_PROG |=> !ext_addr_hi_oe)
        else $error("upper address driven for non-program access");
    a_lo_addr: assert property (
        s_take |=> ext_addr_o[15:0] == $past(core_addr[15:0]))
        else $error("low address differs from request");
    a_host_in: assert property (
        host_port_wide_select |-> !ext_addr_lo_oe)
        else $error("low address driven in host mode");
    a_data_float: assert property (
        !float_n || !hold_ack_n |-> !ext_data_oe)
        else $error("data driven while floated");
    a_read_quiet: assert property (
        s_take ##0 !core_wr |=> !ext_data_oe [*2])
        else $error("data driven during read");
    a_write_drive: assert property (
        s_take_wr ##1 float_n |-> ext_data_oe &&
        ext_data_o == $past(core_wdata))
        else $error("write data not driven");
    a_ack_float: assert property (
        interrupt_acknowledge_oe == float_n)
        else $error("acknowledge enable wrong");
    a_ack_vector: assert property (
        $fell(interrupt_acknowledge_out_n) |->
        ext_addr_o[22:5] == 18'h007fc && ext_addr_o[1:0] == 2'h0)
        else $error("acknowledge outside vector table");
    a_nmi_taken: assert property (
        $fell(nmi_n) && !core_busy && hold_req_n |->
        ##[1:12] !interrupt_acknowledge_out_n)
        else $error("nmi not acknowledged");
    a_holder_keep: assert property (
        $fell(ext_data_oe) && float_n && $past(float_n) |->
        ext_data_keep_o == $past(ext_data_o))
        else $error("holder lost last driven value");
    a_boot_addr: assert property (
        !$past(reset_n) |-> ##[0:2] ext_addr_o == 23'h00ff80)
        else $error("boot fetch address wrong");
endmodule

bind ebx_top ebx_top_monitor #(.ACC_CYC(ACC_CYC)) mon_u (.*);

// ### dv/ebx_ext_mem.sv
// External memory, host address source and bus wire resolver
`timescale 1ns/10ps
module ebx_ext_mem (
    input wire logic mclk,
    input wire logic [22:0] ext_addr_o,
    input wire logic ext_addr_lo_oe,
    input wire logic [15:0] ext_data_o,
    input wire logic ext_data_oe,
    input wire logic [15:0] ext_data_keep_o,
    input wire logic ext_data_keep_oe,
    input wire logic host_port_wide_select,
    input wire logic [15:0] host_a,
    input wire logic drive_en,
    output logic [15:0] ext_addr_i,
    output logic [15:0] ext_data_i
);
    logic [15:0] mem [256];
    logic [15:0] last_d = 16'h0000;
    logic [15:0] last_a = 16'h0000;

    initial begin
        foreach (mem[i])
            mem[i] = 16'h0000;
    end

    always @(posedge mclk) begin
        if (ext_data_oe === 1'b1)
            mem[ext_addr_o[7:0]] <= ext_data_o;
        last_d <= ext_data_i;
        last_a <= ext_addr_i;
    end

    // Keeper is weakest; an undriven wire keeps changing so a missing
    // holder cannot pass by luck
    always_comb begin
        if (ext_data_oe === 1'b1)
            ext_data_i = ext_data_o;
        else if (drive_en && ext_addr_lo_oe === 1'b1)
            ext_data_i = mem[ext_addr_o[7:0]];
        else if (ext_data_keep_oe === 1'b1)
            ext_data_i = ext_data_keep_o;
        else
            ext_data_i = ~last_d;
    end

    always_comb begin
        if (host_port_wide_select)
            ext_addr_i = host_a;
        else if (ext_addr_lo_oe === 1'b1)
            ext_addr_i = ext_addr_o[15:0];
        else
            ext_addr_i = ~last_a;
    end
endmodule

// ### dv/test_ebx_top.sv
// Self-checking bench for the external bus and interrupt pin block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
    begin \
        checks++; \
        if ((gt) !== (ex)) begin \
            n_fail++; \
            $display("[FAIL] %s exp %h got %h", nm, ex, gt); \
        end \
    end
module test_ebx_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, core_wdata = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, core_req = 1'b0, core_wr = 1'b0;
    ebx_pkg::ebx_space_t core_space = ebx_pkg::SP_PROG;
    logic [22:0] core_addr = 23'h000000, ext_addr_o, a;
    logic irq, core_busy, core_done, vec_done, hold_ack_n;
    logic ext_addr_lo_oe, ext_addr_hi_oe, ext_data_oe, ext_data_keep_oe;
    logic interrupt_acknowledge_out_n, interrupt_acknowledge_oe;
    logic [15:0] reg_rdata, core_rdata, vec_addr, ext_addr_i, ext_data_o;
    logic [15:0] ext_data_i, ext_data_keep_o, host_port_addr, d, got, exp_v;
    logic float_n = 1'b1, hold_req_n = 1'b1, nmi_n = 1'b1;
    logic host_port_wide_select = 1'b0;
    logic [3:0] external_interrupt_line_n = 4'hf;
    logic [15:0] host_a = 16'h0000;
    logic [15:0] exp_q[$];
    logic [31:0] lfsr = 32'h0000f23c;
    logic rd_pend = 1'b0, drive_en = 1'b1;
    int n_fail = 0;
    int checks = 0;

    ebx_top #(.ACC_CYC(2)) dut_u (.*);
    ebx_ext_mem mem_u (.*);

    always #10 mclk = ~mclk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic end_sim();
        `CHK("queue", 0, exp_q.size())
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic reg_w(input logic [2:0] ad, input logic [15:0] wd);
        @(posedge mclk);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_r(input logic [2:0] ad, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask

    // Request is held until taken; a read notes the data it expects
    task automatic acc(input ebx_pkg::ebx_space_t sp, input logic wr,
                       input logic [22:0] ad, input logic [15:0] wd);
        int i;
        if (!wr)
            exp_q.push_back(wd);
        @(posedge mclk);
        core_space <= sp;
        core_wr <= wr;
        core_addr <= ad;
        core_wdata <= wd;
        core_req <= 1'b1;
        i = 0;
        do begin
            @(negedge mclk);
            i++;
        end while (core_busy !== 1'b0 && i < 50);
        @(posedge mclk);
        core_req <= 1'b0;
        do begin
            @(negedge mclk);
            i++;
        end while (core_done !== 1'b1 && i < 100);
        `CHK("access end", 1'b1, core_done)
    endtask

    task automatic pulse(input logic [4:0] m);
        @(posedge mclk);
        {nmi_n, external_interrupt_line_n} <= ~m;
        repeat (2) @(posedge mclk);
        {nmi_n, external_interrupt_line_n} <= 5'h1f;
        repeat (16) @(posedge mclk);
    endtask

    always @(negedge mclk) begin
        if ({core_done, core_wr} === 2'b10 || vec_done === 1'b1 || rd_pend) begin
            got = (core_done === 1'b1) ? core_rdata :
                  ((vec_done === 1'b1) ? vec_addr : reg_rdata);
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
            `CHK("result", exp_v, got)
        end
        rd_pend = reg_rd;
    end

    initial begin
        #100000;
        n_fail++;
        $display("[FAIL] watchdog exp done got timeout");
        end_sim();
    end

    initial begin
        exp_q.push_back(16'hff80);
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (10) @(posedge mclk);
        reg_r(3'h0, 16'h0000);
        reg_r(3'h1, 16'h0000);
        reg_r(3'h2, 16'h0001);
        reg_r(3'h3, 16'h0001);
        reg_r(3'h4, 16'h0021);
        reg_w(3'h5, 16'hffff);
        reg_r(3'h5, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            d = lfsr[15:0];
            a = {lfsr[22:16], 8'h00, lfsr[31:24]};
            acc(ebx_pkg::ebx_space_t'(i), 1'b1, a, d);
            acc(ebx_pkg::ebx_space_t'(i), 1'b0, a, d);
        end
        drive_en <= 1'b0;
        acc(ebx_pkg::SP_DATA, 1'b1, a, ~d);
        repeat (3) @(negedge mclk);
        `CHK("held data", ~d, ext_data_i)
        reg_w(3'h2, 16'h0000);
        reg_r(3'h2, 16'h0000);
        @(negedge mclk);
        `CHK("keeper off", 1'b0, ext_data_keep_oe)
        reg_w(3'h2, 16'h0001);
        drive_en <= 1'b1;
        $display("test access done");
        fork
            acc(ebx_pkg::SP_IO, 1'b1, a, d);
            begin
                repeat (2) @(posedge mclk);
                float_n <= 1'b0;
                @(posedge mclk);
                float_n <= 1'b1;
            end
        join
        @(posedge mclk);
        hold_req_n <= 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("hold ack", 1'b0, hold_ack_n)
        `CHK("addr oe in hold", 1'b0, ext_addr_lo_oe)
        @(posedge mclk);
        hold_req_n <= 1'b1;
        host_port_wide_select <= 1'b1;
        host_a <= lfsr[31:16];
        repeat (3) @(negedge mclk);
        `CHK("host addr", host_a, host_port_addr)
        @(posedge mclk);
        host_port_wide_select <= 1'b0;
        $display("test float hold host done");
        reg_w(3'h0, 16'h000f);
        for (int n = 0; n < 4; n++) begin
            reg_w(3'h3, 16'h0000);
            exp_q.push_back(16'hff90 + 16'(4 * n));
            pulse(5'(1 << n));
        end
        reg_w(3'h3, 16'h0000);
        exp_q.push_back(16'hff94);
        exp_q.push_back(16'hff9c);
        pulse(5'h0a);
        reg_w(3'h3, 16'h0000);
        repeat (16) @(posedge mclk);
        reg_w(3'h0, 16'h0000);
        pulse(5'h04);
        @(negedge mclk);
        `CHK("irq masked", 1'b0, irq)
        reg_w(3'h0, 16'h0004);
        @(negedge mclk);
        `CHK("irq unmasked", 1'b1, irq)
        reg_r(3'h1, 16'h0004);
        reg_w(3'h1, 16'h0004);
        reg_r(3'h1, 16'h0000);
        reg_w(3'h0, 16'h0000);
        exp_q.push_back(16'hff84);
        pulse(5'h10);
        $display("test interrupts done");
        end_sim();
    end
endmodule
